// [csf_pkg.sv]
// package for the calibration switch and fault status block
// assumes a 50 MHz system clock and a host-side serial engine outside
package csf_pkg;
    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int CLK_HZ = 50_000_000;
    localparam int HOLD_TIME_S = 8;
    localparam longint HOLD_CYCLES_L = longint'(HOLD_TIME_S) * longint'(CLK_HZ);
    localparam logic [31:0] HOLD_CYCLES = 32'(HOLD_CYCLES_L);
    localparam int HOLD_W = 32;
    // ****************************************************************
    // concentrations and fault byte layout
    // ****************************************************************
    localparam int PPM_W = 16;
    localparam logic [15:0] REF_PPM_RESET = 16'h0190;
    localparam logic [15:0] ZERO_PPM = 16'h0000;
    localparam int FB_FATAL = 0;
    localparam int FB_OFFSET = 1;
    localparam int FB_ALGO = 2;
    localparam int FB_OUTPUT = 3;
    localparam int FB_SELFDIAG = 4;
    localparam int FB_RANGE = 5;
    localparam int FB_MEMORY = 6;
    localparam int FB_RSVD = 7;
    localparam logic [7:0] FAULT_RESET = 8'h00;
    // self-clearing bits follow their condition, the other used bits are sticky
    localparam logic [7:0] AUTO_CLEAR_MASK = 8'h22;
    localparam logic [7:0] USED_MASK = 8'h7f;
    localparam int NUM_PROBES = 4;
    localparam int PROBE_W = 16;
    // controller states
    typedef enum logic [3:0] {
        CSF_POR = 4'h1,
        CSF_SELFTEST = 4'h2,
        CSF_RUN = 4'h4,
        CSF_CAL = 4'h8
    } csf_state_e;
endpackage : csf_pkg

// [csf_hold_timer.sv]
// hold timer for one ground-closing calibration switch
// assumes the switch input is already synchronous to clock
`timescale 1ns/1ps
`default_nettype none
module csf_hold_timer
    import csf_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic switch_n,
    input wire logic [31:0] hold_cycles,
    output logic held
);
    typedef struct packed {
        logic [HOLD_W-1:0] count;
        logic held;
    } csf_hold_s;
    csf_hold_s cur, next_cur;
    // ****************************************************************
    // count closure time, restart on any opening
    // ****************************************************************
    always_comb begin
        next_cur = cur;
        if (switch_n) begin // [R5]
            next_cur.count = '0; // [R16]
            next_cur.held = 1'b0;
        end else if (cur.count >= hold_cycles - 32'h0000_0001) begin
            next_cur.held = 1'b1; // [R1]
        end else begin
            next_cur.count = cur.count + 32'h0000_0001;
        end
    end
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cur <= '0;
        end else if (clk_en) begin
            cur <= next_cur;
        end
    end
    assign held = cur.held;
    a_open_clears: assert property (@(posedge clock) disable iff (rst) // [R16]
        (clk_en && switch_n) |=> (cur.count == '0 && !held))
        else $error("hold timer not restarted on open");
endmodule : csf_hold_timer
`default_nettype wire

// [csf_ref_store.sv]
// stored reference concentration for background calibration
// assumes the serial engine gives a one-cycle write strobe
`timescale 1ns/1ps
`default_nettype none
module csf_ref_store
    import csf_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic ref_wr,
    input wire logic [15:0] ref_wdata,
    output logic [15:0] ref_ppm
);
    typedef struct packed {
        logic [PPM_W-1:0] value;
    } csf_ref_s;
    csf_ref_s cur, next_cur;
    // ****************************************************************
    // host may rewrite the reference value
    // ****************************************************************
    always_comb begin
        next_cur = cur;
        if (ref_wr) begin
            next_cur.value = ref_wdata; // [R6]
        end
    end
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cur.value <= REF_PPM_RESET; // [R2]
        end else if (clk_en) begin
            cur <= next_cur;
        end
    end
    assign ref_ppm = cur.value;
endmodule : csf_ref_store
`default_nettype wire

// [csf_calibration_switch_and_fault_status.sv]
// calibration switches, self-test sequencing and the fault byte
// assumes synchronous inputs, one 50 MHz clock, active-high async reset
// Overview of operation
// [R1] background switch held closed eight seconds starts a background calibration
// [R2] calibration replaces zero constant so reading becomes reference, default 400
// [R3] calibration repeats while the background switch stays closed
// [R4] zero switch does the same with a zero concentration target
// [R5] operator grounds the switch input; low input means request
// [R6] reference concentration is a stored setting writable over serial
// [R7] every power-up runs a full self-test recording failures
// [R8] out-of-range bit set while any probe leaves its valid range
// [R9] every memory write is read back; mismatch sets memory bit
// [R10] status pin high when fault byte is zero, low otherwise
// [R11] byte bits: fatal, offset, algorithm, output, diag, range, memory, reserved
// [R12] offset and range bits clear themselves when the fault goes away
// [R13] other bits stay set until host overwrite or power cycle
// [R14] simultaneous faults are all reported together in one byte
// [R15] host reads the whole fault byte over either serial port
// [R16] hold timer restarts whenever the switch opens early
// [R17] power-on reset clears the fault byte before the self-test
`timescale 1ns/1ps
`default_nettype none
module csf_calibration_switch_and_fault_status
    import csf_pkg::*;
#(
    parameter logic [31:0] HOLD_CYC = HOLD_CYCLES
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic clk_en,
    // switches, low while closed
    input wire logic background_cal_switch_n,
    input wire logic zero_cal_switch_n,
    // sensor core side
    input wire logic [15:0] reading_ppm,
    input wire logic cal_done,
    input wire logic selftest_done,
    input wire logic [7:0] selftest_faults,
    input wire logic fatal_event,
    input wire logic offset_fault,
    input wire logic algo_event,
    input wire logic output_event,
    input wire logic selfdiag_event,
    input wire logic [63:0] probe_values,
    input wire logic [63:0] probe_min,
    input wire logic [63:0] probe_max,
    // memory update and readback
    input wire logic mem_verify,
    input wire logic [7:0] mem_written,
    input wire logic [7:0] mem_readback,
    // host serial engine (either port)
    input wire logic ref_wr,
    input wire logic [15:0] ref_wdata,
    input wire logic fault_wr,
    input wire logic [7:0] fault_wdata,
    output logic [7:0] fault_flags_rdata,
    output logic [15:0] ref_ppm,
    // calibration control to the core
    output logic selftest_start,
    output logic cal_start,
    output logic [15:0] cal_target_ppm,
    output logic [15:0] cal_reading_ppm,
    output logic cal_busy,
    output logic status_ok
);
    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        csf_state_e state;
        logic [7:0] fault_flags;
        logic [15:0] target;
        logic [15:0] reading;
        logic start;
        logic st_start;
        logic status;
    } csf_top_s;
    csf_top_s cur, next_cur;
    logic bg_held;
    logic zero_held;
    logic [NUM_PROBES-1:0] probe_bad;
    logic range_fault;
    logic mem_mismatch;
    logic [7:0] sticky_set;
    logic [7:0] auto_now;
    logic [7:0] next_flags;

    // ****************************************************************
    // switch hold timers and reference store
    // ****************************************************************
    csf_hold_timer u_bg_timer (
        .clock(clock),
        .rst(rst),
        .clk_en(clk_en),
        .switch_n(background_cal_switch_n),
        .hold_cycles(HOLD_CYC),
        .held(bg_held)
    );
    csf_hold_timer u_zero_timer (
        .clock(clock),
        .rst(rst),
        .clk_en(clk_en),
        .switch_n(zero_cal_switch_n),
        .hold_cycles(HOLD_CYC),
        .held(zero_held)
    );
    csf_ref_store u_ref (
        .clock(clock),
        .rst(rst),
        .clk_en(clk_en),
        .ref_wr(ref_wr),
        .ref_wdata(ref_wdata),
        .ref_ppm(ref_ppm)
    );

    // ****************************************************************
    // probe range checks, one per probe
    // ****************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PROBES; gi++) begin : g_probe
            assign probe_bad[gi] = // [R8]
                (probe_values[gi*PROBE_W +: PROBE_W] < probe_min[gi*PROBE_W +: PROBE_W]) ||
                (probe_values[gi*PROBE_W +: PROBE_W] > probe_max[gi*PROBE_W +: PROBE_W]);
        end
    endgenerate
    assign range_fault = |probe_bad;
    // readback comparison on every memory update
    assign mem_mismatch = mem_verify && (mem_written != mem_readback); // [R9]

    // ****************************************************************
    // fault byte sources
    // ****************************************************************
    always_comb begin
        sticky_set = 8'h00;
        sticky_set[FB_FATAL] = fatal_event;
        sticky_set[FB_ALGO] = algo_event;
        sticky_set[FB_OUTPUT] = output_event;
        sticky_set[FB_SELFDIAG] = selfdiag_event;
        sticky_set[FB_MEMORY] = mem_mismatch;
        if (cur.state == CSF_SELFTEST && selftest_done) begin
            sticky_set = sticky_set | (selftest_faults & USED_MASK & ~AUTO_CLEAR_MASK); // [R7]
        end
        auto_now = 8'h00;
        auto_now[FB_OFFSET] = offset_fault;
        auto_now[FB_RANGE] = range_fault;
    end

    // fault byte: host overwrite, set wins over clear, auto bits follow
    always_comb begin
        next_flags = cur.fault_flags;
        if (fault_wr) begin
            next_flags = fault_wdata & USED_MASK; // [R13]
        end
        next_flags = (next_flags & ~AUTO_CLEAR_MASK) | sticky_set; // [R14]
        next_flags = next_flags | auto_now; // [R12]
        next_flags[FB_RSVD] = 1'b0; // [R11]
    end

    // ****************************************************************
    // controller
    // ****************************************************************
    always_comb begin
        next_cur = cur;
        next_cur.start = 1'b0;
        next_cur.st_start = 1'b0;
        next_cur.fault_flags = next_flags;
        unique case (cur.state)
            CSF_POR: begin
                next_cur.fault_flags = FAULT_RESET; // [R17]
                next_cur.st_start = 1'b1; // [R7]
                next_cur.state = CSF_SELFTEST;
            end
            CSF_SELFTEST: begin
                if (selftest_done) begin
                    next_cur.state = CSF_RUN;
                end
            end
            CSF_RUN: begin
                if (bg_held) begin
                    next_cur.target = ref_ppm; // [R2]
                    next_cur.reading = reading_ppm;
                    next_cur.start = 1'b1; // [R1]
                    next_cur.state = CSF_CAL;
                end else if (zero_held) begin
                    next_cur.target = ZERO_PPM; // [R4]
                    next_cur.reading = reading_ppm;
                    next_cur.start = 1'b1;
                    next_cur.state = CSF_CAL;
                end
            end
            CSF_CAL: begin
                if (cal_done) begin
                    // still closed: go round again
                    next_cur.state = CSF_RUN; // [R3]
                end
            end
            default: begin
                next_cur.state = CSF_POR;
            end
        endcase
        next_cur.status = (next_cur.fault_flags == 8'h00); // [R10]
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cur.state <= CSF_POR;
            cur.fault_flags <= FAULT_RESET;
            cur.target <= REF_PPM_RESET;
            cur.reading <= 16'h0000;
            cur.start <= 1'b0;
            cur.st_start <= 1'b0;
            cur.status <= 1'b1;
        end else if (clk_en) begin
            cur <= next_cur;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign fault_flags_rdata = cur.fault_flags; // [R15]
    assign status_ok = cur.status;
    assign cal_start = cur.start;
    assign selftest_start = cur.st_start;
    assign cal_target_ppm = cur.target;
    assign cal_reading_ppm = cur.reading;
    assign cal_busy = (cur.state == CSF_CAL);

    // ****************************************************************
    // checks
    // ****************************************************************
    a_status_pin: assert property (@(posedge clock) disable iff (rst) // [R10]
        status_ok == (fault_flags_rdata == 8'h00))
        else $error("status pin disagrees with fault byte");
    a_range_sets: assert property (@(posedge clock) disable iff (rst) // [R8]
        (clk_en && range_fault && cur.state != CSF_POR) |=> fault_flags_rdata[FB_RANGE])
        else $error("range bit not set");
    a_range_clears: assert property (@(posedge clock) disable iff (rst) // [R12]
        (clk_en && !range_fault && !fault_wr) |=> !fault_flags_rdata[FB_RANGE])
        else $error("range bit did not self clear");
    a_memory_sets: assert property (@(posedge clock) disable iff (rst) // [R9]
        (clk_en && mem_mismatch && cur.state != CSF_POR) |=> fault_flags_rdata[FB_MEMORY])
        else $error("memory mismatch not flagged");
    a_sticky_holds: assert property (@(posedge clock) disable iff (rst) // [R13]
        (clk_en && !fault_wr && cur.state != CSF_POR && fault_flags_rdata[FB_FATAL])
        |=> fault_flags_rdata[FB_FATAL])
        else $error("sticky bit lost without overwrite");
    a_reserved_zero: assert property (@(posedge clock) disable iff (rst) // [R11]
        !fault_flags_rdata[FB_RSVD])
        else $error("reserved bit set");
    a_bg_target: assert property (@(posedge clock) disable iff (rst) // [R2]
        (clk_en && cur.state == CSF_RUN && bg_held) |=> (cal_start && cal_target_ppm == $past(ref_ppm)))
        else $error("background target wrong");
    a_zero_target: assert property (@(posedge clock) disable iff (rst) // [R4]
        (clk_en && cur.state == CSF_RUN && !bg_held && zero_held)
        |=> (cal_start && cal_target_ppm == ZERO_PPM))
        else $error("zero target wrong");
    a_por_clears: assert property (@(posedge clock) disable iff (rst) // [R17]
        (clk_en && cur.state == CSF_POR) |=> (selftest_start && fault_flags_rdata == 8'h00))
        else $error("power-on did not clear byte and start self-test");
    // offset bit tracks its condition every enabled cycle outside CSF_POR
    a_offset_follows: assert property (@(posedge clock) disable iff (rst) // [R12]
        (clk_en && cur.state != CSF_POR)
        |=> (fault_flags_rdata[FB_OFFSET] == $past(offset_fault)))
        else $error("offset bit does not follow its condition");
    // sticky sources land in their own bit, together when coincident
    a_fatal_sets: assert property (@(posedge clock) disable iff (rst) // [R11]
        (clk_en && fatal_event && cur.state != CSF_POR)
        |=> fault_flags_rdata[FB_FATAL])
        else $error("fatal bit not set");
    a_multi_fault: assert property (@(posedge clock) disable iff (rst) // [R14]
        (clk_en && fatal_event && algo_event && cur.state != CSF_POR)
        |=> (fault_flags_rdata[FB_FATAL] && fault_flags_rdata[FB_ALGO]))
        else $error("coincident faults not all reported");
    // host overwrite takes the written value when no event competes
    a_host_clears: assert property (@(posedge clock) disable iff (rst) // [R13]
        (clk_en && fault_wr && !fatal_event && cur.state == CSF_RUN)
        |=> (fault_flags_rdata[FB_FATAL] == $past(fault_wdata[FB_FATAL])))
        else $error("host overwrite not applied");
    // self-test result is loaded into the byte
    a_selftest_loads: assert property (@(posedge clock) disable iff (rst) // [R7]
        (clk_en && cur.state == CSF_SELFTEST && selftest_done && selftest_faults[FB_SELFDIAG])
        |=> fault_flags_rdata[FB_SELFDIAG])
        else $error("self-test failure not recorded");
    // calibration start is a single pulse inside the busy window
    a_start_pulse: assert property (@(posedge clock) disable iff (rst) // [R1]
        (clk_en && cal_start)
        |=> !cal_start)
        else $error("calibration start longer than one cycle");
    a_busy_on_start: assert property (@(posedge clock) disable iff (rst) // [R1]
        cal_start
        |-> cal_busy)
        else $error("calibration start without busy");
    a_cal_returns: assert property (@(posedge clock) disable iff (rst) // [R3]
        (clk_en && cal_busy && cal_done)
        |=> !cal_busy)
        else $error("calibration did not return to run");
    // reference write shows on the next edge
    a_ref_write: assert property (@(posedge clock) disable iff (rst) // [R6]
        (clk_en && ref_wr)
        |=> (ref_ppm == $past(ref_wdata)))
        else $error("reference write not stored");
    // open switches never leave a hold pending
    a_open_no_hold: assert property (@(posedge clock) disable iff (rst) // [R16]
        (clk_en && background_cal_switch_n && zero_cal_switch_n)
        |=> (!bg_held && !zero_held))
        else $error("hold flag set with switches open");
endmodule : csf_calibration_switch_and_fault_status
`default_nettype wire

// [csf_core_model.sv]
// sensor core model answering self-test and calibration requests
// assumes one-cycle start pulses; slow stretches the answer delay
`timescale 1ns/1ps
`default_nettype none
module csf_core_model
    import csf_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic slow,
    input wire logic selftest_start,
    input wire logic cal_start,
    output logic selftest_done,
    output logic cal_done
);
    // ****************************************************************
    // delayed one-cycle answers
    // ****************************************************************
    int st_cnt;
    int cal_cnt;
    // count down after each start, pulse done at the end
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_cnt <= 0;
            cal_cnt <= 0;
            selftest_done <= 1'b0;
            cal_done <= 1'b0;
        end else begin
            selftest_done <= (st_cnt == 1);
            cal_done <= (cal_cnt == 1);
            st_cnt <= selftest_start ? (slow ? 12 : 3) : (st_cnt > 0 ? st_cnt - 1 : 0);
            cal_cnt <= cal_start ? (slow ? 12 : 2) : (cal_cnt > 0 ? cal_cnt - 1 : 0);
        end
    end
endmodule : csf_core_model
`default_nettype wire

// [tb_top.sv]
// self-checking bench for the calibration switch and fault status block
// assumes the core model in csf_core_model and a 50 MHz clock
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import csf_pkg::*;
;
    typedef struct packed {logic [6:0] ev; logic [7:0] exp;} csf_row_s;
    localparam logic [63:0] NORM = 64'h01f4_01f4_01f4_01f4;
    localparam logic [63:0] BAD = 64'h01f4_07d0_01f4_01f4;
    // event vector: memory, range, diag, output, algo, offset, fatal
    localparam csf_row_s ROWS [8] = '{'{7'h01, 8'h01}, '{7'h02, 8'h02},
        '{7'h04, 8'h04}, '{7'h08, 8'h08}, '{7'h10, 8'h10}, '{7'h20, 8'h20},
        '{7'h40, 8'h40}, '{7'h25, 8'h25}};
    logic clock, rst = 1, bg_n = 1, zero_n = 1, slow = 0, st_done, c_done;
    logic fatal = 0, offs = 0, algo = 0, outp = 0, diag = 0, en = 1;
    logic mver = 0, fwr = 0, rwr = 0, st_start, c_start, busy, ok;
    logic [7:0] st_f = 8'hb2, mrb = 8'h5a, fwd = 8'h00, flags;
    logic [15:0] reading = 16'h0000, rwd = 16'h0000, ref_ppm, tgt, c_rd;
    logic [63:0] pv = NORM;
    int err_count = 0, checked = 0, n;
    // ****************************************************************
    // clock, design and core model
    // ****************************************************************
    initial begin
        clock = 0;
        forever #10 clock = ~clock;
    end
    csf_calibration_switch_and_fault_status #(.HOLD_CYC(32'h0000_0014)) DUT (
        .clock(clock), .rst(rst), .clk_en(en),
        .background_cal_switch_n(bg_n), .zero_cal_switch_n(zero_n),
        .reading_ppm(reading), .cal_done(c_done), .selftest_done(st_done),
        .selftest_faults(st_f), .fatal_event(fatal), .offset_fault(offs),
        .algo_event(algo), .output_event(outp), .selfdiag_event(diag),
        .probe_values(pv), .probe_min(64'h0064_0064_0064_0064),
        .probe_max(64'h03e8_03e8_03e8_03e8), .mem_verify(mver),
        .mem_written(8'h5a), .mem_readback(mrb), .ref_wr(rwr), .ref_wdata(rwd),
        .fault_wr(fwr), .fault_wdata(fwd), .fault_flags_rdata(flags),
        .ref_ppm(ref_ppm), .selftest_start(st_start), .cal_start(c_start),
        .cal_target_ppm(tgt), .cal_reading_ppm(c_rd), .cal_busy(busy), .status_ok(ok));
    csf_core_model core (.clock(clock), .rst(rst), .slow(slow),
        .selftest_start(st_start), .cal_start(c_start),
        .selftest_done(st_done), .cal_done(c_done));
    // ****************************************************************
    // tasks
    // ****************************************************************
    task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task settle();
        repeat (3) @(posedge clock);
        #1;
    endtask : settle
    // raise events for one cycle, level faults stay up
    task apply(input logic [6:0] ev);
        @(posedge clock);
        {mver, diag, outp, algo, offs, fatal} <= {ev[6], ev[4:0]};
        pv <= ev[5] ? BAD : NORM;
        mrb <= ev[6] ? 8'h5b : 8'h5a;
        @(posedge clock);
        {mver, diag, outp, algo, fatal} <= '0;
        settle();
    endtask : apply
    // host overwrite of the fault byte
    task host_wr(input logic [7:0] v);
        @(posedge clock);
        offs <= 1'b0;
        pv <= NORM;
        fwr <= 1'b1;
        fwd <= v;
        @(posedge clock);
        fwr <= 1'b0;
        settle();
    endtask : host_wr
    task wait_start();
        n = 0;
        do begin
            @(posedge clock);
            #1;
            n++;
        end while (c_start !== 1'b1 && n < 200);
        if (c_start !== 1'b1) err_count++;
    endtask : wait_start
    task wait_idle();
        settle();
        n = 0;
        while (busy !== 1'b0 && n < 100) begin
            @(posedge clock);
            #1;
            n++;
        end
        if (busy !== 1'b0) err_count++;
    endtask : wait_idle
    task give_verdict();
        $display("mismatches %0d comparisons %0d", err_count, checked);
        if (err_count == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : give_verdict
    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        #1 chk("ref_ppm", ref_ppm, 16'h0190);
        @(posedge clock);
        #1 chk("selftest_start", st_start, 1'b1);
        repeat (11) @(posedge clock);
        #1 chk("flags", flags, 8'h10);
        chk("status_ok", ok, 1'b0);
        host_wr(8'h00);
        chk("status_ok", ok, 1'b1);
        foreach (ROWS[i]) begin
            apply(ROWS[i].ev);
            chk("flags", flags, ROWS[i].exp);
            chk("status_ok", ok, 1'b0);
            host_wr(8'h00);
            chk("flags", flags, 8'h00);
        end
        apply(7'h22);
        chk("flags", flags, 8'h22);
        @(posedge clock);
        offs <= 1'b0;
        pv <= NORM;
        settle();
        chk("flags", flags, 8'h00);
        host_wr(8'hff);
        chk("flags", flags, 8'h5d);
        host_wr(8'h00);
        // frozen clock enable: overwrite ignored, sticky bit kept
        apply(7'h01);
        @(posedge clock);
        en <= 1'b0;
        host_wr(8'h00);
        @(posedge clock);
        en <= 1'b1;
        #1 chk("flags", flags, 8'h01);
        host_wr(8'h00);
        apply(7'h00);
        @(posedge clock);
        mver <= 1'b1;
        @(posedge clock);
        mver <= 1'b0;
        settle();
        chk("flags", flags, 8'h00);
        @(posedge clock);
        rwr <= 1'b1;
        rwd <= 16'h03e8;
        @(posedge clock);
        rwr <= 1'b0;
        #1 chk("ref_ppm", ref_ppm, 16'h03e8);
        // early opening then a full hold, grounded means closed
        @(posedge clock);
        reading <= 16'h0222;
        slow <= 1'b1;
        bg_n <= 1'b0;
        repeat (10) @(posedge clock);
        bg_n <= 1'b1;
        @(posedge clock);
        bg_n <= 1'b0;
        wait_start();
        chk("hold_ok", (n >= 20 && n <= 24), 1'b1);
        chk("target", tgt, 16'h03e8);
        chk("reading", c_rd, 16'h0222);
        chk("cal_busy", busy, 1'b1);
        wait_start();
        chk("repeat_ok", (n >= 12 && n <= 18), 1'b1);
        @(posedge clock);
        bg_n <= 1'b1;
        slow <= 1'b0;
        wait_idle();
        @(posedge clock);
        zero_n <= 1'b0;
        wait_start();
        chk("zero_target", tgt, 16'h0000);
        @(posedge clock);
        zero_n <= 1'b1;
        wait_idle();
        apply(7'h01);
        @(posedge clock);
        st_f <= 8'h00;
        rst <= 1'b1;
        #1 chk("flags", flags, 8'h00);
        chk("ref_ppm", ref_ppm, 16'h0190);
        @(posedge clock);
        rst <= 1'b0;
        repeat (12) @(posedge clock);
        #1 chk("flags", flags, 8'h00);
        chk("status_ok", ok, 1'b1);
        give_verdict();
    end
    // hang guard, well beyond the expected run
    initial begin
        #400_000;
        err_count++;
        give_verdict();
    end
endmodule : tb_top
`default_nettype wire
